// ### src/wdtm_top.sv
// Contract
// - Watchdog runs only when mode select and run enable are both 1.
// - Counter overflow asserts the active-low overflow output.
// - Overflow pulse lasts 132 states with reset enable, else 130.
// - With reset enable, chip reset starts together with overflow out.
// - Overflow chip reset stays asserted for 518 states.
// - External pin reset wins over overflow reset and clears the flag.
// - Control, counter and reset status registers read at fixed addresses.
`timescale 1ns/1ns
module wdtm_top (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic external_reset_pin_n_in,
   input wire logic [17:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic overflow_out_n_out,
   output logic chip_reset_out
);
   // ********************************************************************
   // Pin synchroniser
   // ********************************************************************
   logic pin_meta_ff;
   logic pin_sync_ff;
   logic pin_reset;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_meta_ff <= 1'b1;
         pin_sync_ff <= 1'b1;
      end else begin
         pin_meta_ff <= external_reset_pin_n_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   assign pin_reset = ~pin_sync_ff;

   // ********************************************************************
   // Bus decode
   // ********************************************************************
   logic ack;
   logic [15:0] idx;
   logic word_write;
   logic [7:0] key;
   logic [7:0] wdata;

   wdtm_bus u_bus (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .read_in(avs_read_in),
      .write_in(avs_write_in),
      .waitrequest_out(avs_waitrequest_out),
      .ack_out(ack)
   );

   assign idx = avs_address_in[17:2];
   assign key = avs_writedata_in[15:8];
   assign wdata = avs_writedata_in[7:0];
   // Byte writes are dropped so a runaway store cannot feed the dog
   assign word_write = ack & avs_write_in & (avs_byteenable_in[1:0] == 2'h3);

   function automatic logic keyed(input logic [15:0] i,
                                  input logic [15:0] want,
                                  input logic [7:0] k,
                                  input logic [7:0] kw);
      keyed = (i == want) && (k == kw);
   endfunction : keyed

   logic wr_ctrl;
   logic wr_cnt;
   logic wr_rst;

   assign wr_ctrl = word_write &
      keyed(idx, wdtm_pkg::CTRL_IDX, key, wdtm_pkg::KEY_CTRL);
   assign wr_cnt = word_write &
      keyed(idx, wdtm_pkg::CNT_IDX, key, wdtm_pkg::KEY_CNT);
   assign wr_rst = word_write &
      keyed(idx, wdtm_pkg::RST_IDX, key, wdtm_pkg::KEY_RST);

   // ********************************************************************
   // Control and status registers
   // ********************************************************************
   logic [7:0] ctrl_ff;
   logic [7:0] rst_ff;
   logic [7:0] cnt_ff;
   logic ovf_flag_ff;
   logic overflow;
   logic run;
   wdtm_pkg::wdtm_ctrl_t cfg;

   always_ff @(posedge clk_in) begin
      if (reset_in || pin_reset) begin
         ctrl_ff <= wdtm_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= wdata & wdtm_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || pin_reset) begin
         rst_ff <= wdtm_pkg::RST_RESET;
      end else if (wr_rst) begin
         rst_ff <= wdata & wdtm_pkg::RST_WMASK;
      end
   end

   assign cfg.run = ctrl_ff[wdtm_pkg::MODE_BIT] &
                    ctrl_ff[wdtm_pkg::RUN_BIT];
   assign cfg.reset_on_overflow_enable = rst_ff[wdtm_pkg::RESET_ON_OVERFLOW_ENABLE_BIT];
   assign run = cfg.run;

   // Flag survives the internal reset it causes; the pin, reset_in or a keyed write with bit 7 low clears it
   always_ff @(posedge clk_in) begin
      if (reset_in || pin_reset) begin
         ovf_flag_ff <= 1'b0;
      end else if (overflow) begin
         ovf_flag_ff <= 1'b1;
      end else if (wr_rst && !wdata[wdtm_pkg::FLAG_BIT]) begin
         ovf_flag_ff <= 1'b0;
      end
   end

   // ********************************************************************
   // Counter
   // ********************************************************************
   logic [wdtm_pkg::PRESCALE-1:0] pre_ff;
   logic tick;

   always_ff @(posedge clk_in) begin
      if (reset_in || pin_reset || !run) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + 1'b1;
      end
   end

   assign tick = run && (pre_ff == '1);
   // Software rewrite wins over a tick: this is how the dog is fed
   assign overflow = tick && (cnt_ff == 8'hFF) && !wr_cnt && !pin_reset;

   always_ff @(posedge clk_in) begin
      if (reset_in || pin_reset) begin
         cnt_ff <= wdtm_pkg::CNT_RESET;
      end else if (wr_cnt) begin
         cnt_ff <= wdata;
      end else if (tick) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // ********************************************************************
   // Overflow pulse and internal chip reset
   // ********************************************************************
   logic [wdtm_pkg::PULSE_W-1:0] ovf_len;
   logic ovf_active;
   logic chip_active;
   logic chip_start;

   assign ovf_len = cfg.reset_on_overflow_enable ? wdtm_pkg::PULSE_W'(wdtm_pkg::PULSE_LONG)
                    : wdtm_pkg::PULSE_W'(wdtm_pkg::PULSE_SHORT);
   assign chip_start = overflow & cfg.reset_on_overflow_enable;

   wdtm_pulse u_ovf (
      .clk_in(clk_in),
      .reset_in(reset_in | pin_reset),
      .start_in(overflow),
      .len_in(ovf_len),
      .active_out(ovf_active)
   );

   wdtm_pulse u_chip (
      .clk_in(clk_in),
      .reset_in(reset_in | pin_reset),
      .start_in(chip_start),
      .len_in(wdtm_pkg::PULSE_W'(wdtm_pkg::CHIP_RESET_LEN)),
      .active_out(chip_active)
   );

   wdtm_pkg::wdtm_out_t outs;
   assign outs.ovf_n = ~ovf_active;
   assign outs.chip_reset = chip_active;
   assign overflow_out_n_out = outs.ovf_n;
   assign chip_reset_out = outs.chip_reset;

   // ********************************************************************
   // Read data
   // ********************************************************************
   logic [31:0] readdata_ff;
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (avs_address_in[1:0] == 2'h0) begin
         unique case (idx)
            wdtm_pkg::CTRL_IDX: rd_byte = ctrl_ff;
            wdtm_pkg::CNT_IDX: rd_byte = cnt_ff;
            wdtm_pkg::RST_IDX: rd_byte = {ovf_flag_ff,
                                          rst_ff[6:0]};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read_in && avs_waitrequest_out) begin
         readdata_ff <= {24'h000000, rd_byte};
      end
   end

   assign avs_readdata_out = readdata_ff;
endmodule : wdtm_top

// ### src/wdtm_pkg.sv
package wdtm_pkg;
   // ********************************************************************
   // Register map (word index, byte address is four times the index)
   // ********************************************************************
   localparam logic [15:0] CTRL_IDX = 16'hFFBC;
   localparam logic [15:0] CNT_IDX = 16'hFFBD;
   localparam logic [15:0] RST_IDX = 16'hFFBF;
   localparam logic [15:0] KEY_IDX = 16'hFFC0;
   localparam logic [15:0] ADDR_BASE_HI = 16'h0000;

   // ********************************************************************
   // Keyed write format: key byte in [15:8], data in [7:0]
   // ********************************************************************
   localparam logic [7:0] KEY_CTRL = 8'hA5;
   localparam logic [7:0] KEY_CNT = 8'h5A;
   localparam logic [7:0] KEY_RST = 8'hC3;

   // ********************************************************************
   // Fields
   // ********************************************************************
   localparam int MODE_BIT = 6;
   localparam int RUN_BIT = 5;
   localparam int OVF_BIT = 7;
   localparam int FLAG_BIT = 7;
   localparam int RESET_ON_OVERFLOW_ENABLE_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] RST_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h60;
   localparam logic [7:0] RST_WMASK = 8'h40;

   // ********************************************************************
   // Timing: pulse lengths in states of the system clock, PRESCALE and PULSE_W are counter widths in bits
   // ********************************************************************
   localparam int PULSE_LONG = 132;
   localparam int PULSE_SHORT = 130;
   localparam int CHIP_RESET_LEN = 518;
   localparam int PRESCALE = 2;
   localparam int PULSE_W = 10;

   typedef struct packed {
      logic run;
      logic reset_on_overflow_enable;
   } wdtm_ctrl_t;

   typedef struct packed {
      logic ovf_n;
      logic chip_reset;
   } wdtm_out_t;
endpackage : wdtm_pkg

// ### src/wdtm_pulse.sv
`timescale 1ns/1ns
module wdtm_pulse (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic [wdtm_pkg::PULSE_W-1:0] len_in,
   output logic active_out
);
   logic [wdtm_pkg::PULSE_W-1:0] cnt_ff;

   // Restart on a new start so an overlapping event stretches the pulse
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cnt_ff <= '0;
      end else if (start_in) begin
         cnt_ff <= len_in;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign active_out = (cnt_ff != '0);
endmodule : wdtm_pulse

// ### src/wdtm_bus.sv
`timescale 1ns/1ns
module wdtm_bus (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic read_in,
   input wire logic write_in,
   output logic waitrequest_out,
   output logic ack_out
);
   logic done_ff;

   // One wait state per access keeps read data a flop, never a mux path
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (read_in | write_in) & ~done_ff;
      end
   end

   assign ack_out = (read_in | write_in) & done_ff;
   assign waitrequest_out = (read_in | write_in) & ~done_ff;
endmodule : wdtm_bus

// ### verification/wdtm_top_sva.sv
`timescale 1ns/1ns
// ****
// Port checks
// ****
module wdtm_sva (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic external_reset_pin_n_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic overflow_out_n_out,
   input wire logic chip_reset_out
);
   logic [9:0] lo_ff;
   logic [9:0] cr_ff;
   logic req;
   assign req = avs_read_in || avs_write_in;
   // Pulse lengths counted here, far cheaper than long repetitions
   always_ff @(posedge clk_in) begin
      lo_ff <= overflow_out_n_out ? 10'h000 : lo_ff + 10'h001;
   end
   always_ff @(posedge clk_in) begin
      cr_ff <= chip_reset_out ? cr_ff + 10'h001 : 10'h000;
   end
   default clocking @(posedge clk_in); endclocking
   // Pin reset cuts pulses short on purpose
   default disable iff (reset_in || !external_reset_pin_n_in);
   ovf_len_a: assert property ($rose(overflow_out_n_out) |->
      lo_ff == (chip_reset_out ? 10'h084 : 10'h082))
      else $error("overflow pulse length wrong");
   cr_len_a: assert property ($fell(chip_reset_out) |->
      cr_ff == 10'h206) else $error("chip reset length wrong");
   cr_start_a: assert property ($rose(chip_reset_out) |->
      $fell(overflow_out_n_out)) else $error("chip reset not aligned");
   ovf_hold_a: assert property ($fell(overflow_out_n_out) |=>
      !overflow_out_n_out [*8]) else $error("overflow pulse too short");
   one_wait_a: assert property (req && avs_waitrequest_out |=>
      !avs_waitrequest_out) else $error("more than one wait cycle");
   first_wait_a: assert property ($rose(req) |->
      avs_waitrequest_out) else $error("no wait cycle");
   idle_wait_a: assert property (!req |->
      !avs_waitrequest_out) else $error("wait while idle");
   rd_hi_a: assert property (avs_read_in && !avs_waitrequest_out |->
      avs_readdata_out[31:8] == 24'h000000) else $error("read high bits");
   cover property ($rose(chip_reset_out));
   cover property ($fell(overflow_out_n_out) && !chip_reset_out);
   cover property (avs_write_in && !avs_waitrequest_out);
endmodule : wdtm_sva

// ### verification/wdtm_host.sv
`timescale 1ns/1ns
// ****
// Bus master standing in for software
// ****
module wdtm_host (
   input wire logic clk_in,
   input wire logic [31:0] readdata_in,
   input wire logic waitrequest_in,
   output logic [17:0] address_out,
   output logic read_out,
   output logic write_out,
   output logic [31:0] writedata_out
);
   initial begin
      address_out = 18'h00000;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h00000000;
   end
   // Held until waitrequest is seen low, released only after that edge
   task acc(input logic w, input logic [15:0] i, input logic [15:0] d,
            output logic [7:0] r);
      @(posedge clk_in);
      address_out <= {i, 2'h0};
      read_out <= !w;
      write_out <= w;
      writedata_out <= {16'h0000, d};
      // Sampled at the rising edge only, so no half-cycle release race
      @(posedge clk_in);
      while (waitrequest_in !== 1'b0) @(posedge clk_in);
      r = readdata_in[7:0];
      read_out <= 1'b0;
      write_out <= 1'b0;
   endtask : acc
endmodule : wdtm_host

// ### verification/test_wdtm_top.sv
`timescale 1ns/1ns
// ****
// Watchdog bench
// ****
module test_wdtm_top;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic pin_n = 1'b1;
   logic [3:0] be = 4'hF;
   logic [17:0] addr;
   logic rd_s, wr_s, wq, ovf_n, cr;
   logic [31:0] wdat, rdat;
   logic [7:0] v;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   int lo_seen = 0;
   always #4 clk_in = ~clk_in;
   wdtm_top wdtm_top_i (.clk_in(clk_in), .reset_in(reset_in),
      .external_reset_pin_n_in(pin_n), .avs_address_in(addr),
      .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat),
      .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wq), .overflow_out_n_out(ovf_n),
      .chip_reset_out(cr));
   wdtm_host wdtm_host_i (.clk_in(clk_in), .readdata_in(rdat),
      .waitrequest_in(wq), .address_out(addr), .read_out(rd_s),
      .write_out(wr_s), .writedata_out(wdat));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   always @(posedge clk_in) begin
      cyc++;
      if (ovf_n === 1'b0) lo_seen++;
      if (cyc == 12000) begin
         fails++;
         test_done();
      end
   end
   task rr(input logic [15:0] i, input logic [7:0] e, input string n);
      wdtm_host_i.acc(1'b0, i, 16'h0000, v);
      chk(n, {24'h000000, v}, {24'h000000, e});
   endtask : rr
   task ww(input logic [15:0] i, input logic [7:0] k, input logic [7:0] d);
      wdtm_host_i.acc(1'b1, i, {k, d}, v);
   endtask : ww
   task t_regs;
      rr(wdtm_pkg::CTRL_IDX, wdtm_pkg::CTRL_RESET, "ctrl");
      rr(wdtm_pkg::CNT_IDX, wdtm_pkg::CNT_RESET, "cnt");
      rr(wdtm_pkg::RST_IDX, wdtm_pkg::RST_RESET, "rst");
      rr(16'hFFBE, 8'h00, "unmapped");
      ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_RST, 8'h77);
      rr(wdtm_pkg::CNT_IDX, 8'h00, "bad key");
      be <= 4'h1;
      ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_CNT, 8'h33);
      be <= 4'hF;
      rr(wdtm_pkg::CNT_IDX, 8'h00, "byte write");
      ww(wdtm_pkg::CTRL_IDX, wdtm_pkg::KEY_CTRL, 8'hFF);
      rr(wdtm_pkg::CTRL_IDX, wdtm_pkg::CTRL_WMASK, "ctrl mask");
      $display("t_regs done");
   endtask : t_regs
   task t_off;
      for (int i = 0; i < 2; i++) begin
         ww(wdtm_pkg::CTRL_IDX, wdtm_pkg::KEY_CTRL, i ? 8'h20 : 8'h40);
         ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_CNT, 8'hF0);
         lo_seen = 0;
         repeat (1100) @(posedge clk_in);
         chk("half enable", lo_seen, 0);
         rr(wdtm_pkg::CNT_IDX, 8'hF0, "held");
      end
      $display("t_off done");
   endtask : t_off
   task t_kick;
      ww(wdtm_pkg::CTRL_IDX, wdtm_pkg::KEY_CTRL, 8'h60);
      lo_seen = 0;
      repeat (3) begin
         ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_CNT, 8'h00);
         repeat (600) @(posedge clk_in);
      end
      chk("kicked", lo_seen, 0);
      $display("t_kick done");
   endtask : t_kick
   task t_ovf(input logic e);
      int n;
      int lo;
      int crc;
      ww(wdtm_pkg::RST_IDX, wdtm_pkg::KEY_RST, {1'b0, e, 6'h00});
      ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_CNT, 8'hFE);
      n = 0;
      lo = 0;
      crc = 0;
      while (ovf_n !== 1'b0 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      chk("same cycle", cr, e);
      while (ovf_n === 1'b0 || cr === 1'b1) begin
         lo += (ovf_n === 1'b0);
         crc += (cr === 1'b1);
         @(negedge clk_in);
      end
      chk("pulse", lo, e ? wdtm_pkg::PULSE_LONG : wdtm_pkg::PULSE_SHORT);
      chk("chip reset", crc, e ? wdtm_pkg::CHIP_RESET_LEN : 0);
      rr(wdtm_pkg::RST_IDX, {1'b1, e, 6'h00}, "flag");
      ww(wdtm_pkg::RST_IDX, wdtm_pkg::KEY_RST, 8'h00);
      rr(wdtm_pkg::RST_IDX, 8'h00, "flag clear");
      $display("t_ovf done");
   endtask : t_ovf
   task t_pin;
      ww(wdtm_pkg::RST_IDX, wdtm_pkg::KEY_RST, 8'h40);
      ww(wdtm_pkg::CNT_IDX, wdtm_pkg::KEY_CNT, 8'hFF);
      pin_n <= 1'b0;
      repeat (20) @(posedge clk_in);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk_in);
      rr(wdtm_pkg::RST_IDX, 8'h00, "pin flag");
      rr(wdtm_pkg::CTRL_IDX, 8'h00, "pin ctrl");
      chk("pin chip reset", cr, 1'b0);
      $display("t_pin done");
   endtask : t_pin
   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_off();
      t_kick();
      t_ovf(1'b1);
      t_ovf(1'b0);
      t_pin();
      test_done();
   end
endmodule : test_wdtm_top
bind wdtm_top wdtm_sva wdtm_sva_i (.clk_in(clk_in), .reset_in(reset_in),
   .external_reset_pin_n_in(external_reset_pin_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .overflow_out_n_out(overflow_out_n_out),
   .chip_reset_out(chip_reset_out));
